// File: logic/ttc_core.sv
/*
 * Triple 16-bit timer/counter core with AXI4-Lite register access.
 * Assumes clock is the oscillator; count and interrupt pins are
 * synchronous to it; a service pulse register stands in for the core's
 * interrupt acknowledge.
 */
// Chosen here: the AXI4-Lite interface to the registers.
`default_nettype none
module ttc_core
    import ttc_pkg::*;
(
    input wire logic clock, // Oscillator clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [TTC_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [TTC_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read response ready
    input wire logic count_pin_zero, // Event input, timer 0
    input wire logic count_pin_one, // Event input, timer 1
    input wire logic count_pin_two, // Event input, timer 2
    input wire logic ext_irq_pin_zero, // External interrupt 0 and gate 0
    input wire logic ext_irq_pin_one, // External interrupt 1 and gate 1
    output logic irq // Level interrupt
);
    // ========================================================
    // Registers
    logic [7:0] timer_control;
    logic [7:0] timer_mode_config;
    logic [7:0] timer2_control;
    logic [7:0] cnt_low [3];
    logic [7:0] cnt_high [3];
    logic [7:0] timer2_capture_low;
    logic [7:0] timer2_capture_high;
    logic [TTC_IRQ_N-1:0] irq_status;
    logic [TTC_IRQ_N-1:0] irq_enable;
    ttc_mode_s mode0;
    ttc_mode_s mode1;
    assign mode0 = timer_mode_config[3:0];
    assign mode1 = timer_mode_config[7:4];

    // ========================================================
    // Tick divider, free running from the oscillator
    logic [3:0] tick_cnt;
    logic tick;
    always_ff @(posedge clock) begin
        if (!rst_n || tick_cnt == TTC_TICK_LAST) begin
            tick_cnt <= 4'h0;
        end else begin
            tick_cnt <= tick_cnt + 4'h1;
        end
    end
    assign tick = (tick_cnt == TTC_TICK_LAST);

    // ========================================================
    // Pin sampling: falling edge seen across two ticks, counted two ticks after the second
    logic [2:0] pins;
    logic [2:0] samp_prev;
    logic [2:0] samp_cur;
    logic [2:0] edge_pend;
    assign pins = {count_pin_two, count_pin_one, count_pin_zero};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            samp_prev <= 3'h0;
            samp_cur <= 3'h0;
            edge_pend <= 3'h0;
        end else if (tick) begin
            samp_cur <= pins;
            samp_prev <= samp_cur;
            edge_pend <= samp_prev & ~samp_cur;
        end
    end

    // ========================================================
    // Enables: event pulse per timer, gated by run and, for timers 0 and 1, gate
    logic [2:0] inc;
    logic th0_inc;
    logic run0;
    logic run1;
    logic run2;
    assign run0 = timer_control[TTC_CTL_TR0]
        && (!mode0.gate || ext_irq_pin_zero);
    assign run1 = timer_control[TTC_CTL_TR1]
        && (!mode1.gate || ext_irq_pin_one);
    assign run2 = timer2_control[TTC_T2_RUN];
    // Counter select chooses pin edge over internal tick
    assign inc[0] = run0 && tick && (mode0.csel ? edge_pend[0] : 1'b1);
    assign inc[1] = run1 && tick && (mode1.csel ? edge_pend[1] : 1'b1)
        && mode1.mode != TTC_MODE_SPLIT && mode0.mode != TTC_MODE_SPLIT;
    assign inc[2] = run2 && tick
        && (timer2_control[TTC_T2_CSEL] ? edge_pend[2] : 1'b1);
    // Split mode: high byte of timer 0 is a plain timer on timer 1's run bit
    assign th0_inc = tick && timer_control[TTC_CTL_TR1] && mode0.mode == TTC_MODE_SPLIT;

    // ========================================================
    // Count arithmetic for timers 0 and 1 by mode
    logic [7:0] next_low [3];
    logic [7:0] next_high [3];
    logic [2:0] ovf;
    logic th0_ovf;
    always_comb begin
        ttc_mode_s m;
        m = mode0;
        th0_ovf = 1'b0;
        for (int i = 0; i < 3; i++) begin
            next_low[i] = cnt_low[i];
            next_high[i] = cnt_high[i];
            ovf[i] = 1'b0;
        end
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? mode0 : mode1;
            if (inc[i]) begin
                case (m.mode)
                    TTC_MODE_13: begin
                        next_low[i] = {cnt_low[i][7:5], cnt_low[i][4:0] + 5'h01};
                        if (cnt_low[i][4:0] == 5'h1F) begin
                            next_high[i] = cnt_high[i] + 8'h01;
                            ovf[i] = (cnt_high[i] == 8'hFF);
                        end
                    end
                    TTC_MODE_16: begin
                        {next_high[i], next_low[i]} = {cnt_high[i], cnt_low[i]} + 16'h0001;
                        ovf[i] = ({cnt_high[i], cnt_low[i]} == 16'hFFFF);
                    end
                    TTC_MODE_RELOAD: begin
                        if (cnt_low[i] == 8'hFF) begin
                            next_low[i] = cnt_high[i];
                            ovf[i] = 1'b1;
                        end else begin
                            next_low[i] = cnt_low[i] + 8'h01;
                        end
                    end
                    default: begin
                        // Split: low byte of timer 0 counts alone
                        next_low[i] = cnt_low[i] + 8'h01;
                        ovf[i] = (cnt_low[i] == 8'hFF) && (i == 0);
                    end
                endcase
            end
        end
        if (th0_inc) begin
            next_high[0] = cnt_high[0] + 8'h01;
            th0_ovf = (cnt_high[0] == 8'hFF);
        end
        if (inc[2]) begin
            {next_high[2], next_low[2]} = {cnt_high[2], cnt_low[2]} + 16'h0001;
            ovf[2] = ({cnt_high[2], cnt_low[2]} == 16'hFFFF);
            if (ovf[2] && timer2_control[TTC_T2_RELOAD]) begin
                next_high[2] = timer2_capture_high;
                next_low[2] = timer2_capture_low;
            end
        end
    end

    // ========================================================
    // AXI4-Lite write channel
    logic aw_held;
    logic w_held;
    logic [TTC_ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane;
    logic wr_go;
    logic [7:0] wr_idx;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign wr_go = aw_held && w_held;
    assign wr_idx = aw_addr[9:2];
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= TTC_AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map(wr_idx) ? TTC_AXI_OKAY : TTC_AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_map(input logic [7:0] idx);
        case (idx)
            TTC_IDX_CONTROL, TTC_IDX_MODE, TTC_IDX_T0_LOW, TTC_IDX_T1_LOW,
            TTC_IDX_T0_HIGH, TTC_IDX_T1_HIGH, TTC_IDX_T2_CAP_LOW,
            TTC_IDX_T2_CAP_HIGH, TTC_IDX_T2_LOW, TTC_IDX_T2_HIGH,
            TTC_IDX_T2_CTRL, TTC_IDX_IRQ_STATUS, TTC_IDX_IRQ_ENABLE,
            TTC_IDX_IRQ_CLEAR, TTC_IDX_SERVICE: wr_map = 1'b1;
            default: wr_map = 1'b0;
        endcase
    endfunction : wr_map

    logic we;
    assign we = wr_go && w_lane;

    // ========================================================
    // Counter bytes: software write beats counting on that byte only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                cnt_low[i] <= 8'h00;
                cnt_high[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                cnt_low[i] <= next_low[i];
                cnt_high[i] <= next_high[i];
            end
            if (we) begin
                case (wr_idx)
                    TTC_IDX_T0_LOW: cnt_low[0] <= w_byte;
                    TTC_IDX_T0_HIGH: cnt_high[0] <= w_byte;
                    TTC_IDX_T1_LOW: cnt_low[1] <= w_byte;
                    TTC_IDX_T1_HIGH: cnt_high[1] <= w_byte;
                    TTC_IDX_T2_LOW: cnt_low[2] <= w_byte;
                    TTC_IDX_T2_HIGH: cnt_high[2] <= w_byte;
                    default: ;
                endcase
            end
        end
    end

    // ========================================================
    // Configuration and capture registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_mode_config <= TTC_MOD_RESET;
            timer2_capture_low <= 8'h00;
            timer2_capture_high <= 8'h00;
            irq_enable <= '0;
        end else if (we) begin
            case (wr_idx)
                TTC_IDX_MODE: timer_mode_config <= w_byte;
                TTC_IDX_T2_CAP_LOW: timer2_capture_low <= w_byte;
                TTC_IDX_T2_CAP_HIGH: timer2_capture_high <= w_byte;
                TTC_IDX_IRQ_ENABLE: irq_enable <= w_byte[TTC_IRQ_N-1:0];
                default: ;
            endcase
        end
    end

    // ========================================================
    // External interrupt detection
    logic [1:0] ext_prev;
    logic [1:0] ext_event;
    logic [1:0] ext_pins;
    assign ext_pins = {ext_irq_pin_one, ext_irq_pin_zero};
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ext_prev <= 2'h3;
        end else begin
            ext_prev <= ext_pins;
        end
    end
    assign ext_event[0] = timer_control[TTC_CTL_IT0] ? (ext_prev[0] && !ext_pins[0])
        : !ext_pins[0];
    assign ext_event[1] = timer_control[TTC_CTL_IT1] ? (ext_prev[1] && !ext_pins[1])
        : !ext_pins[1];

    // ========================================================
    // Control register: flags set by hardware win over service clears
    logic svc_we;
    logic [7:0] svc;
    assign svc_we = we && wr_idx == TTC_IDX_SERVICE;
    assign svc = svc_we ? w_byte : 8'h00;
    logic t1_flag_set;
    assign t1_flag_set = ovf[1] || th0_ovf;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer_control <= TTC_CTL_RESET;
        end else begin
            if (we && wr_idx == TTC_IDX_CONTROL) begin
                // Only run and trigger bits are writable
                timer_control[TTC_CTL_TR1] <= w_byte[TTC_CTL_TR1];
                timer_control[TTC_CTL_TR0] <= w_byte[TTC_CTL_TR0];
                timer_control[TTC_CTL_IT1] <= w_byte[TTC_CTL_IT1];
                timer_control[TTC_CTL_IT0] <= w_byte[TTC_CTL_IT0];
            end
            // Service write bit positions match the flag positions
            timer_control[TTC_CTL_TF1] <= t1_flag_set
                || (timer_control[TTC_CTL_TF1] && !svc[TTC_CTL_TF1]);
            timer_control[TTC_CTL_TF0] <= ovf[0]
                || (timer_control[TTC_CTL_TF0] && !svc[TTC_CTL_TF0]);
            timer_control[TTC_CTL_IE1] <= ext_event[1]
                || (timer_control[TTC_CTL_IE1] && !svc[TTC_CTL_IE1]);
            timer_control[TTC_CTL_IE0] <= ext_event[0]
                || (timer_control[TTC_CTL_IE0] && !svc[TTC_CTL_IE0]);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            timer2_control <= 8'h00;
        end else begin
            if (we && wr_idx == TTC_IDX_T2_CTRL) begin
                timer2_control[2:0] <= w_byte[2:0];
            end
            timer2_control[TTC_T2_FLAG] <= ovf[2]
                || (timer2_control[TTC_T2_FLAG] && !svc[TTC_T2_FLAG]);
        end
    end

    // ========================================================
    // Sticky interrupt status, clear register, enable, level output
    logic [TTC_IRQ_N-1:0] irq_set;
    logic [TTC_IRQ_N-1:0] irq_clr;
    assign irq_set = {ext_event[1], ext_event[0], ovf[2], t1_flag_set, ovf[0]};
    assign irq_clr = (we && wr_idx == TTC_IDX_IRQ_CLEAR) ? w_byte[TTC_IRQ_N-1:0] : '0;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= irq_set | (irq_status & ~irq_clr);
            irq <= |(irq_status & irq_enable);
        end
    end

    // ========================================================
    // AXI4-Lite read channel
    logic [7:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr[9:2])
            TTC_IDX_CONTROL: rd_val = timer_control;
            TTC_IDX_MODE: rd_val = timer_mode_config;
            TTC_IDX_T0_LOW: rd_val = cnt_low[0];
            TTC_IDX_T1_LOW: rd_val = cnt_low[1];
            TTC_IDX_T0_HIGH: rd_val = cnt_high[0];
            TTC_IDX_T1_HIGH: rd_val = cnt_high[1];
            TTC_IDX_T2_CAP_LOW: rd_val = timer2_capture_low;
            TTC_IDX_T2_CAP_HIGH: rd_val = timer2_capture_high;
            TTC_IDX_T2_LOW: rd_val = cnt_low[2];
            TTC_IDX_T2_HIGH: rd_val = cnt_high[2];
            TTC_IDX_T2_CTRL: rd_val = timer2_control;
            TTC_IDX_IRQ_STATUS: rd_val = {3'h0, irq_status};
            TTC_IDX_IRQ_ENABLE: rd_val = {3'h0, irq_enable};
            TTC_IDX_IRQ_CLEAR, TTC_IDX_SERVICE: rd_val = 8'h00;
            default: begin
                rd_val = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= TTC_AXI_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_val};
            s_axi_rresp <= rd_ok ? TTC_AXI_OKAY : TTC_AXI_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : ttc_core
`default_nettype wire

// File: inc/ttc_pkg.sv
/*
 * Package for the triple timer/counter core: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a single 125 MHz clock standing in for the oscillator.
 */
`default_nettype none
package ttc_pkg;
    // ========================================================
    // Register word indices, address bits [9:2] (printed offsets are not all word aligned)
    localparam logic [7:0] TTC_IDX_CONTROL = 8'h88;
    localparam logic [7:0] TTC_IDX_MODE = 8'h89;
    localparam logic [7:0] TTC_IDX_T0_LOW = 8'h8A;
    localparam logic [7:0] TTC_IDX_T1_LOW = 8'h8B;
    localparam logic [7:0] TTC_IDX_T0_HIGH = 8'h8C;
    localparam logic [7:0] TTC_IDX_T1_HIGH = 8'h8D;
    localparam logic [7:0] TTC_IDX_T2_CAP_LOW = 8'hCA;
    localparam logic [7:0] TTC_IDX_T2_CAP_HIGH = 8'hCB;
    localparam logic [7:0] TTC_IDX_T2_LOW = 8'hCC;
    localparam logic [7:0] TTC_IDX_T2_HIGH = 8'hCD;
    localparam logic [7:0] TTC_IDX_T2_CTRL = 8'hC8;
    localparam logic [7:0] TTC_IDX_IRQ_STATUS = 8'hF0;
    localparam logic [7:0] TTC_IDX_IRQ_ENABLE = 8'hF1;
    localparam logic [7:0] TTC_IDX_IRQ_CLEAR = 8'hF2;
    localparam logic [7:0] TTC_IDX_SERVICE = 8'hF3;
    localparam int TTC_ADDR_W = 10;
    // ========================================================
    // Control register fields
    localparam int TTC_CTL_TF1 = 7;
    localparam int TTC_CTL_TR1 = 6;
    localparam int TTC_CTL_TF0 = 5;
    localparam int TTC_CTL_TR0 = 4;
    localparam int TTC_CTL_IE1 = 3;
    localparam int TTC_CTL_IT1 = 2;
    localparam int TTC_CTL_IE0 = 1;
    localparam int TTC_CTL_IT0 = 0;
    localparam logic [7:0] TTC_CTL_RESET = 8'h00;
    localparam logic [7:0] TTC_CTL_SW_MASK = 8'h55;
    // Mode register: per timer {gate, counter_select, mode[1:0]}, timer 1 high
    localparam int TTC_MOD_GATE = 3;
    localparam int TTC_MOD_CSEL = 2;
    localparam logic [7:0] TTC_MOD_RESET = 8'h00;
    // Timer 2 control: bit 0 run, bit 1 counter select, bit 2 reload on overflow
    localparam int TTC_T2_RUN = 0;
    localparam int TTC_T2_CSEL = 1;
    localparam int TTC_T2_RELOAD = 2;
    localparam int TTC_T2_FLAG = 7;
    // Interrupt status layout: bit 0 t0 ovf, 1 t1 ovf, 2 t2 ovf, 3 ext0, 4 ext1
    localparam int TTC_IRQ_N = 5;
    // Mode encodings
    localparam logic [1:0] TTC_MODE_13 = 2'h0;
    localparam logic [1:0] TTC_MODE_16 = 2'h1;
    localparam logic [1:0] TTC_MODE_RELOAD = 2'h2;
    localparam logic [1:0] TTC_MODE_SPLIT = 2'h3;
    // ========================================================
    // Timing
    localparam int TTC_CLK_MHZ = 125;
    localparam int TTC_TICK_OSC_PERIODS = 12;
    localparam logic [3:0] TTC_TICK_LAST = 4'(TTC_TICK_OSC_PERIODS - 1);
    localparam logic [1:0] TTC_AXI_OKAY = 2'h0;
    localparam logic [1:0] TTC_AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic gate;
        logic csel;
        logic [1:0] mode;
    } ttc_mode_s;
endpackage : ttc_pkg
`default_nettype wire

// File: verif/ttc_pins.sv
/* Partner model: drives the three count pins and the two interrupt pins.
   Assumes the bench's clock; requests arrive as levels. */
`default_nettype none
module ttc_pins (
    input wire logic clock, // Clock
    input wire logic [2:0] count_run, // Toggle request per count pin
    input wire logic [1:0] ext_level, // Wanted interrupt pin levels
    output logic [2:0] count_pins, // Count pins
    output logic [1:0] ext_pins // Interrupt pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] phase = 5'h00;
    logic [2:0] lvl = 3'h7;
    logic [1:0] ext = 2'h3;
    assign count_pins = lvl;
    assign ext_pins = ext;
    // Each level lasts two sample periods, so no level can slip between samples
    always_ff @(posedge clock) begin
        phase <= (phase == 5'h17) ? 5'h00 : phase + 5'h01;
        if (phase == 5'h17) lvl <= lvl ^ count_run;
        ext <= ext_level;
    end
endmodule : ttc_pins
`default_nettype wire

// File: verif/ttc_core_checker.sv
/* Checker: register bus relations at the timer core's ports.
   Assumes one clock and a synchronous active-low reset. */
`default_nettype none
module ttc_core_checker
    import ttc_pkg::*;
(
    input wire logic clock, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic s_axi_awvalid, // Write address valid
    input wire logic s_axi_awready, // Write address ready
    input wire logic s_axi_wvalid, // Write data valid
    input wire logic s_axi_wready, // Write data ready
    input wire logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready // Read response ready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ====================
    // Bus steps
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_read_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_write_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == TTC_AXI_SLVERR
        |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
endmodule : ttc_core_checker
bind ttc_core ttc_core_checker ttc_core_checker_i (.clock(clock), .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: verif/ttc_core_bench.sv
/* Bench: register-level tests of the timer core over AXI4-Lite.
   Assumes the pin model ttc_pins and a fixed one-cycle read answer. */
`default_nettype none
module ttc_core_bench
    import ttc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata, d1, d2;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, r, ext_level = 2'h3;
    logic [2:0] count_run = 3'h0, cpin;
    logic [1:0] epin;
    logic [7:0] tab [8] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
    int failures = 0, samples_checked = 0, cyc = 0, t_rd, n;
    initial forever #4 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    ttc_pins ttc_pins_i (.clock(clock), .count_run(count_run), .ext_level(ext_level),
        .count_pins(cpin), .ext_pins(epin));
    ttc_core ttc_core_i (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_pin_zero(cpin[0]), .count_pin_one(cpin[1]), .count_pin_two(cpin[2]),
        .ext_irq_pin_zero(epin[0]), .ext_irq_pin_one(epin[1]), .irq(irq));
    // ====================
    // Bus tasks and compares
    task automatic chk_data(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk_data
    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_data(what, {31'h0, e}, {31'h0, g});
    endtask : chk_bit
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 64) begin failures++; tally_and_finish(); end
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clock);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clock);
            if (arvalid && arready) t_rd = cyc;
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 64) begin failures++; tally_and_finish(); end
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        rd(idx, d1, r);
        chk_data("read data", e, d1);
        chk_data("read resp", {30'h0, TTC_AXI_OKAY}, {30'h0, r});
    endtask : rdchk
    // Count advance over exactly span clocks, independent of tick phase
    task automatic rate(input logic [7:0] idx, input int span, input logic [7:0] e);
        int t1;
        rd(idx, d1, r);
        t1 = t_rd;
        while (cyc < t1 + span - 2) @(posedge clock);
        rd(idx, d2, r);
        chk_data("count step", {24'h0, e}, {24'h0, d2[7:0] - d1[7:0]});
    endtask : rate
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // ====================
    // Tests
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(8'h88, 32'h0);
        rdchk(8'h89, 32'h0);
        wr(8'h88, 8'hFF);
        rdchk(8'h88, 32'h55);
        wr(8'h88, 8'h00);
        foreach (tab[i]) wr(tab[i], tab[i] ^ 8'h5A);
        foreach (tab[i]) rdchk(tab[i], {24'h0, tab[i] ^ 8'h5A});
        rd(8'h40, d1, r);
        chk_data("unmapped resp", {30'h0, TTC_AXI_SLVERR}, {30'h0, r});
        chk_data("unmapped data", 32'h0, d1);
        wr(8'h40, 8'h00);
        chk_data("unmapped wresp", {30'h0, TTC_AXI_SLVERR}, {30'h0, bresp});
        $display("registers done");
        wr(8'h89, 8'h01);
        wr(8'h88, 8'h10);
        rate(8'h8A, 120, 8'd10);
        rate(8'h8B, 120, 8'd0);
        wr(8'h89, 8'h09);
        ext_level <= 2'h2;
        repeat (24) @(posedge clock);
        rate(8'h8A, 120, 8'd0);
        ext_level <= 2'h3;
        repeat (24) @(posedge clock);
        rate(8'h8A, 120, 8'd10);
        rdchk(8'h88, 32'h12);
        wr(8'hF3, 8'h02);
        rdchk(8'h88, 32'h10);
        wr(8'h89, 8'h05);
        wr(8'hC8, 8'h03);
        count_run <= 3'h5;
        repeat (100) @(posedge clock);
        rate(8'h8A, 480, 8'd10);
        rate(8'hCC, 480, 8'd10);
        count_run <= 3'h0;
        $display("counting done");
        wr(8'h88, 8'h01);
        ext_level <= 2'h2;
        repeat (4) @(posedge clock);
        rdchk(8'h88, 32'h03);
        wr(8'hF3, 8'h02);
        rdchk(8'h88, 32'h01);
        ext_level <= 2'h3;
        $display("external flags done");
        wr(8'hF2, 8'h1F);
        wr(8'h89, 8'h02);
        wr(8'h8C, 8'hF0);
        wr(8'h8A, 8'hFE);
        wr(8'hF1, 8'h01);
        wr(8'h88, 8'h10);
        repeat (60) @(posedge clock);
        rdchk(8'h88, 32'h30);
        wr(8'h88, 8'h00);
        rdchk(8'h8C, 32'hF0);
        rd(8'h8A, d1, r);
        chk_data("reload low", 32'hF, d1 >> 4);
        chk_bit("irq", 1'b1, irq);
        wr(8'hF3, 8'h20);
        rdchk(8'h88, 32'h0);
        wr(8'hF1, 8'h00);
        repeat (2) @(posedge clock);
        chk_bit("irq", 1'b0, irq);
        wr(8'hF1, 8'h01);
        repeat (2) @(posedge clock);
        chk_bit("irq", 1'b1, irq);
        wr(8'hF2, 8'h01);
        repeat (2) @(posedge clock);
        chk_bit("irq", 1'b0, irq);
        $display("overflow done");
        tally_and_finish();
    end
endmodule : ttc_core_bench
`default_nettype wire
